// ==== program_counter_rom_sequencer_test.sv ====
`timescale 1ns/1ps
module program_counter_rom_sequencer_test;
   import prs_pkg::*;
   typedef logic [15:0] img_t [ROM_WORDS];
   function automatic img_t mk();
      img_t m;
      foreach (m[i]) m[i] = {5'h15, 11'(i)};
      return m;
   endfunction : mk
   logic i_ref_clk = 0, i_rstn = 0, done = 0, rd = 0;
   logic [3:0] q = '0;
   logic [10:0] opr = '0, o_pc;
   logic [11:0] idx = '0;
   logic [15:0] o_instr, w;
   logic [7:0] o_table_data, b;
   logic [2:0] o_stack_ptr;
   logic o_table_valid, o_table_range_err;
   prs_op_t op = PRS_OP_NEXT;
   int error_cnt = 0, comparisons = 0, pc = 0, sp = 7, lb = 0, v, stk[8];
   int al[5] = '{0, 1, 255, 256, 4095};
   prs_sequencer #(.ROM_INIT(mk())) i_dut (.i_ref_clk, .i_rstn, .o_pc,
      .i_instr_done(done), .i_op(op), .i_operand(opr), .i_irq_pin(q[3]),
      .i_irq_portc(q[2]), .i_irq_timer1(q[1]), .i_irq_prediv(q[0]),
      .i_table_rd(rd), .i_index_address_pointer(idx), .o_instr, .o_stack_ptr,
      .o_table_data, .o_table_valid, .o_table_range_err);
   prs_rom_model i_rom (.i_pc(pc[10:0]), .i_idx(idx), .o_word(w), .o_byte(b));
   initial forever #50 i_ref_clk = ~i_ref_clk;
   initial begin
      #500000 error_cnt++;
      test_done();
   end
   task automatic test_done;
      if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic step(prs_op_t o, int t, logic [3:0] r);
      @(posedge i_ref_clk);
      done <= 1;
      op <= o;
      opr <= t[10:0];
      q <= r;
      v = o == PRS_OP_HOLD ? pc : (pc + 1) % 2048;
      if (r != 0) pc = r[3] ? 16 : r[2] ? 20 : r[1] ? 24 : 28;
      else if (o == PRS_OP_NEXT) pc = v;
      else if (o == PRS_OP_RETURN) pc = stk[sp];
      else if (o != PRS_OP_HOLD) pc = t & 2047;
      if (r != 0 || o == PRS_OP_CALL) begin
         sp = (sp + 1) % 8;
         stk[sp] = v;
      end else if (o == PRS_OP_RETURN) sp = (sp + 7) % 8;
      @(posedge i_ref_clk);
      done <= 0;
      #1;
      chk("pc", 16'(pc), 16'(o_pc));
      chk("sp", 16'(sp), 16'(o_stack_ptr));
      chk("instr", pc < 1024 ? w : '0, o_instr);
   endtask : step
   task automatic tbl(int a);
      @(posedge i_ref_clk);
      rd <= 1;
      idx <= a[11:0];
      @(posedge i_ref_clk);
      rd <= 0;
      #1;
      if (a < 256) lb = b;
      chk("valid", 16'(a < 256), 16'(o_table_valid));
      chk("range", 16'(a > 255), 16'(o_table_range_err));
      chk("byte", 16'(lb), 16'(o_table_data));
   endtask : tbl
   initial begin
      void'($urandom(32'h66f2));
      repeat (6) @(posedge i_ref_clk);
      i_rstn <= 1;
      #1;
      chk("reset pc", 0, 16'(o_pc));
      for (int i = 0; i < 9; i++) step(PRS_OP_CALL, i * 200 + 9, 0);
      repeat (400) step(prs_op_t'($urandom % 6), $urandom,
         $urandom % 5 ? 4'h0 : 4'($urandom));
      foreach (al[i]) tbl(al[i]);
      repeat (30) tbl($urandom % 512);
      test_done();
   end
endmodule : program_counter_rom_sequencer_test

// ==== prs_checker.sv ====
`timescale 1ns/1ps
module prs_checker
   import prs_pkg::*;
(
   input wire logic i_ref_clk, i_rstn, i_instr_done,
   input wire prs_op_t i_op,
   input wire logic [PC_W-1:0] i_operand, o_pc,
   input wire logic i_irq_pin, i_irq_portc, i_irq_timer1, i_irq_prediv,
   input wire logic [SP_W-1:0] o_stack_ptr
);
   wire logic [3:0] irq = {i_irq_pin, i_irq_portc, i_irq_timer1, i_irq_prediv};
   wire logic go = i_instr_done && irq == 4'h0;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   chk_reset_state: assert property (disable iff (1'b0)
      !i_rstn |=> o_pc == '0) else $error("pc not cleared");
   chk_pc_inc: assert property (go && i_op == PRS_OP_NEXT
      |=> o_pc == $past(o_pc) + 1'b1) else $error("pc not stepped");
   chk_jump_load: assert property (go && i_op inside {PRS_OP_JUMP,
      PRS_OP_CALL, PRS_OP_BRANCH} |=> o_pc == $past(i_operand))
      else $error("bad target");
   chk_pin_vec: assert property (i_instr_done && i_irq_pin
      |=> o_pc == VEC_INT_PIN) else $error("pin vector");
   chk_prediv_vec: assert property (i_instr_done && irq == 4'h1
      |=> o_pc == VEC_PREDIV) else $error("prediv vector");
   chk_push_ptr: assert property (go && i_op == PRS_OP_CALL
      |=> o_stack_ptr == $past(o_stack_ptr) + 1'b1) else $error("no push");
   chk_pop_ptr: assert property (go && i_op == PRS_OP_RETURN
      |=> o_stack_ptr == $past(o_stack_ptr) - 1'b1) else $error("no pop");
   chk_idle_hold: assert property (!i_instr_done
      |=> $stable(o_pc) && $stable(o_stack_ptr)) else $error("pc moved");
   cover property (go && i_op == PRS_OP_RETURN && o_stack_ptr == SP_RESET);
   cover property (i_instr_done && i_irq_timer1);
   cover property (go && i_op == PRS_OP_HOLD);
endmodule : prs_checker
bind prs_sequencer prs_checker i_chk (.*);

// ==== prs_pkg.sv ====
package prs_pkg;
   localparam int PC_W = 11;
   localparam int ROM_WORDS = 1152;
   localparam int ROM_W = 16;
   localparam int TBL_W = 8;
   localparam int IDX_W = 12;
   localparam int STK_DEPTH = 8;
   localparam int SP_W = 3;
   localparam int INSTRUCTION_AREA_PAGE = 128;
   localparam int TABLE_AREA_PAGE = 256;
   localparam int PART_MAX = 9;
   localparam logic [PC_W-1:0] VEC_RESET = 11'h000;
   localparam logic [PC_W-1:0] VEC_INT_PIN = 11'h010;
   localparam logic [PC_W-1:0] VEC_PORTC = 11'h014;
   localparam logic [PC_W-1:0] VEC_TIMER1 = 11'h018;
   localparam logic [PC_W-1:0] VEC_PREDIV = 11'h01c;
   localparam logic [SP_W-1:0] SP_RESET = 3'h7;
   typedef enum logic [2:0] {
      PRS_OP_NEXT,
      PRS_OP_JUMP,
      PRS_OP_CALL,
      PRS_OP_BRANCH,
      PRS_OP_RETURN,
      PRS_OP_HOLD
   } prs_op_t;
endpackage : prs_pkg

// ==== prs_rom_model.sv ====
`timescale 1ns/1ps
module prs_rom_model (
   input wire logic [10:0] i_pc,
   input wire logic [11:0] i_idx,
   output logic [15:0] o_word,
   output logic [7:0] o_byte
);
   // Table sits above the 1024 instruction words
   wire logic [15:0] tw = {5'h15, 11'h400 + 11'(i_idx[11:1])};
   assign o_word = {5'h15, i_pc};
   assign o_byte = i_idx[0] ? tw[15:8] : tw[7:0];
endmodule : prs_rom_model

// ==== prs_sequencer.sv ====
`timescale 1ns/1ps
module prs_sequencer
   import prs_pkg::*;
#(
   parameter int PARTITION_N = 8,
   parameter logic [ROM_W-1:0] ROM_INIT [ROM_WORDS] = '{default: 16'h0000}
) (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic i_instr_done,
   input wire prs_op_t i_op,
   input wire logic [PC_W-1:0] i_operand,
   input wire logic i_irq_pin,
   input wire logic i_irq_portc,
   input wire logic i_irq_timer1,
   input wire logic i_irq_prediv,
   input wire logic i_table_rd,
   input wire logic [IDX_W-1:0] i_index_address_pointer,
   output logic [PC_W-1:0] o_pc,
   output logic [ROM_W-1:0] o_instr,
   output logic [TBL_W-1:0] o_table_data,
   output logic o_table_valid,
   output logic o_table_range_err,
   output logic [SP_W-1:0] o_stack_ptr
);
   // Fixed mask option, checked at elaboration
   // Out-of-range option falls back to the nearest legal split, since
   // the mask cannot change once the part is built
   localparam int PART_LO = (PARTITION_N < 1) ? 1 : PARTITION_N;
   localparam int PART_N = (PART_LO > PART_MAX) ? PART_MAX : PART_LO;
   localparam int INSTRUCTION_AREA_WORDS = INSTRUCTION_AREA_PAGE * PART_N;
   localparam int TABLE_AREA_BYTES = TABLE_AREA_PAGE * (PART_MAX - PART_N);
   localparam logic [IDX_W:0] TABLE_AREA_LIMIT = (IDX_W+1)'(TABLE_AREA_BYTES);

   logic [ROM_W-1:0] rom [ROM_WORDS];
   logic [PC_W-1:0] stack [STK_DEPTH];
   logic [PC_W-1:0] pc;
   logic [SP_W-1:0] sp;

   // Contents of the mask ROM are fixed at build time
   for (genvar g = 0; g < ROM_WORDS; g++) begin : g_rom
      assign rom[g] = ROM_INIT[g];
   end

   wire irq_any = i_irq_pin | i_irq_portc | i_irq_timer1 | i_irq_prediv;
   // Fixed priority between simultaneous requests; the lower ones stay
   // pending at their source and are taken at a later instruction end
   wire sel_pin = i_irq_pin;
   wire sel_portc = ~i_irq_pin & i_irq_portc;
   wire sel_timer1 = ~i_irq_pin & ~i_irq_portc & i_irq_timer1;
   wire [PC_W-1:0] irq_vec = sel_pin ? VEC_INT_PIN :
                             sel_portc ? VEC_PORTC :
                             sel_timer1 ? VEC_TIMER1 :
                             VEC_PREDIV;

   wire is_hold = (i_op == PRS_OP_HOLD);
   wire is_call = (i_op == PRS_OP_CALL);
   wire is_ret = (i_op == PRS_OP_RETURN);
   wire step = i_instr_done & ~is_hold;
   // An interrupt taken at the end of an instruction wins over its op
   wire do_irq = i_instr_done & irq_any;
   wire do_call = step & ~irq_any & is_call;
   wire do_ret = step & ~irq_any & is_ret;
   wire do_push = do_irq | do_call;
   wire [SP_W-1:0] push_sp = sp + 3'h1;
   wire [SP_W-1:0] pop_sp = sp - 3'h1;
   // The interrupted instruction resumes after the one just completed
   wire [PC_W-1:0] pc_inc = pc + 11'h001;
   // A held instruction has not completed, so it runs again on return
   wire [PC_W-1:0] ret_addr = (do_irq && is_hold) ? pc : pc_inc;
   // Pointer names the newest entry; reset at level 7 so first push is 0
   wire [PC_W-1:0] stack_top = stack[sp];
   // Push and pop never coincide: a call and a return are one op
   wire [SP_W-1:0] next_sp = do_push ? push_sp :
                             do_ret ? pop_sp :
                             sp;

   logic [PC_W-1:0] next_pc;
   always_comb begin
      next_pc = pc;
      if (do_irq) begin
         next_pc = irq_vec;
      end else if (step) begin
         unique case (i_op)
            PRS_OP_JUMP, PRS_OP_CALL: begin
               next_pc = i_operand[PC_W-1:0];
            end
            PRS_OP_BRANCH: begin
               next_pc = i_operand;
            end
            PRS_OP_RETURN: begin
               next_pc = stack_top;
            end
            PRS_OP_NEXT: begin
               next_pc = pc_inc;
            end
            default: begin
               next_pc = pc;
            end
         endcase
      end
   end

   wire [PC_W-1:0] fetch_addr = next_pc;
   wire fetch_ok = {1'b0, fetch_addr} < (PC_W+1)'(INSTRUCTION_AREA_WORDS);
   // Table bytes sit above the instruction area, two per ROM word
   // With N of nine the limit is zero and every read is refused
   wire tbl_ok = {1'b0, i_index_address_pointer} < TABLE_AREA_LIMIT;
   wire tbl_odd = i_index_address_pointer[0];
   wire [IDX_W-2:0] tbl_pair = i_index_address_pointer[IDX_W-1:1];
   wire [IDX_W:0] tbl_word_full =
      (IDX_W+1)'(INSTRUCTION_AREA_WORDS) + {2'b00, tbl_pair};
   // Index beyond the ROM is cut, but such reads are refused anyway
   wire [PC_W-1:0] tbl_word = tbl_word_full[PC_W-1:0];
   wire [ROM_W-1:0] tbl_raw = rom[tbl_word];
   wire [TBL_W-1:0] tbl_byte = tbl_odd ? tbl_raw[ROM_W-1:TBL_W] :
                               tbl_raw[TBL_W-1:0];

   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         pc <= VEC_RESET;
      end else begin
         pc <= next_pc;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         sp <= SP_RESET;
      end else begin
         sp <= next_sp;
      end
   end

   // Stack storage carries no reset, as a plain register file; with
   // no overflow flag a ninth push silently overwrites level 0
   for (genvar g = 0; g < STK_DEPTH; g++) begin : g_stack
      wire hit = do_push & (push_sp == SP_W'(g));
      always_ff @(posedge i_ref_clk) begin
         if (i_rstn && hit) begin
            stack[g] <= ret_addr;
         end
      end
   end

   // Out-of-area fetch returns zero rather than table bytes
   wire [ROM_W-1:0] next_instr = fetch_ok ? rom[fetch_addr] : 16'h0000;
   wire next_table_valid = i_table_rd & tbl_ok;
   wire next_table_err = i_table_rd & ~tbl_ok;
   // Only a good read replaces the byte, so a refused one keeps the last
   wire [TBL_W-1:0] next_table_data = next_table_valid ? tbl_byte :
                                      o_table_data;

   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         o_pc <= VEC_RESET;
      end else begin
         o_pc <= next_pc;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         o_instr <= 16'h0000;
      end else begin
         o_instr <= next_instr;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         o_table_valid <= 1'b0;
         o_table_range_err <= 1'b0;
      end else begin
         o_table_valid <= next_table_valid;
         o_table_range_err <= next_table_err;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         o_table_data <= 8'h00;
      end else begin
         o_table_data <= next_table_data;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         o_stack_ptr <= SP_RESET;
      end else begin
         o_stack_ptr <= next_sp;
      end
   end
endmodule : prs_sequencer
